/* File: hw/dprt_remap_table.sv */
`timescale 1ns/100ps
// What this block does
// - index 0x344 holds the priorities for codes 0x09 (bits 6:4) and 0x08 (bits 2:0), read-write.
// - index 0x345 holds the priorities for codes 0x0B (bits 6:4) and 0x0A (bits 2:0), read-write.
// - index 0x346 holds the priorities for codes 0x0D (bits 6:4) and 0x0C (bits 2:0), read-write.
// - index 0x347 holds the priorities for codes 0x0F (bits 6:4) and 0x0E (bits 2:0), read-write.
// - index 0x348 holds the priorities for codes 0x11 (bits 6:4) and 0x10 (bits 2:0), read-write.
// - index 0x349 holds the priorities for codes 0x13 (bits 6:4) and 0x12 (bits 2:0), read-write.
// - index 0x34A holds the priorities for codes 0x15 (bits 6:4) and 0x14 (bits 2:0), read-write.
// - index 0x34B holds the priorities for codes 0x17 (bits 6:4) and 0x16 (bits 2:0), read-write.
// - index 0x34C holds the priorities for codes 0x19 (bits 6:4) and 0x18 (bits 2:0), read-write.
// - index 0x34D holds the priorities for codes 0x1B (bits 6:4) and 0x1A (bits 2:0), read-write.
// - index 0x34E holds the priorities for codes 0x1D (bits 6:4) and 0x1C (bits 2:0), read-write.
// - table priorities are used only while the remap enable bit is set.
// - with remapping off the priority is code bits 5:3 and the table is ignored.
module dprt_remap_table (
	// clock, reset, enable
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	// apb slave
	input  wire dprt_pkg::dprt_apb_req_t     apb_req,
	output      logic [dprt_pkg::DATA_W-1:0] prdata,
	output      logic                        pready,
	output      logic                        pslverr,
	// classifier lookup
	input  wire dprt_pkg::dprt_lkp_req_t     lkp_req,
	output      dprt_pkg::dprt_lkp_res_t     lkp_res
);
	logic [dprt_pkg::NUM_MAP-1:0][7:0]   map_ff;
	logic                                remap_en_ff;
	logic [dprt_pkg::CNT_W-1:0]          cnt_ff [dprt_pkg::NUM_CNT];
	logic [dprt_pkg::NUM_CNT-1:0]        cnt_evt;
	logic [dprt_pkg::NUM_CNT-1:0]        cnt_clr;
	logic [13:0]                         last_ff;
	logic [9:0]                          idx;
	logic                                aligned;
	logic                                mapped;
	logic                                wr_fire;
	logic [dprt_pkg::DATA_W-1:0]         rd_data;

	assign idx     = apb_req.paddr[dprt_pkg::ADDR_W-1:2];
	assign aligned = apb_req.paddr[1:0] == 2'h0;

	dprt_apb_slave u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.req     (apb_req),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rd_data (rd_data),
		.mapped  (mapped),
		.wr_fire (wr_fire)
	);

	// read decode; unmapped or misaligned reads zero with an error
	always_comb begin
		rd_data = '0;
		mapped  = aligned;
		if (idx == dprt_pkg::IDX_REMAP_EN) begin
			rd_data[dprt_pkg::EN_BIT] = remap_en_ff;
		end else if (idx == dprt_pkg::IDX_MAP_08_09) begin
			rd_data[7:0] = map_ff[0];
		end else if (idx == dprt_pkg::IDX_MAP_0A_0B) begin
			rd_data[7:0] = map_ff[1];
		end else if (idx == dprt_pkg::IDX_MAP_0C_0D) begin
			rd_data[7:0] = map_ff[2];
		end else if (idx == dprt_pkg::IDX_MAP_0E_0F) begin
			rd_data[7:0] = map_ff[3];
		end else if (idx == dprt_pkg::IDX_MAP_10_11) begin
			rd_data[7:0] = map_ff[4];
		end else if (idx == dprt_pkg::IDX_MAP_12_13) begin
			rd_data[7:0] = map_ff[5];
		end else if (idx == dprt_pkg::IDX_MAP_14_15) begin
			rd_data[7:0] = map_ff[6];
		end else if (idx == dprt_pkg::IDX_MAP_16_17) begin
			rd_data[7:0] = map_ff[7];
		end else if (idx == dprt_pkg::IDX_MAP_18_19) begin
			rd_data[7:0] = map_ff[8];
		end else if (idx == dprt_pkg::IDX_MAP_1A_1B) begin
			rd_data[7:0] = map_ff[9];
		end else if (idx == dprt_pkg::IDX_MAP_1C_1D) begin
			rd_data[7:0] = map_ff[10];
		end else if (idx == dprt_pkg::IDX_LAST_LKP) begin
			rd_data[13:0] = last_ff;
		end else if (idx == dprt_pkg::IDX_CNT_REMAP) begin
			rd_data[dprt_pkg::CNT_W-1:0] = cnt_ff[0];
		end else if (idx == dprt_pkg::IDX_CNT_DIRECT) begin
			rd_data[dprt_pkg::CNT_W-1:0] = cnt_ff[1];
		end else if (idx == dprt_pkg::IDX_CNT_MISS) begin
			rd_data[dprt_pkg::CNT_W-1:0] = cnt_ff[2];
		end else begin
			mapped = 1'b0;
		end
	end

	// priority table storage
	for (genvar i = 0; i < dprt_pkg::NUM_MAP; i++) begin : g_map
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				map_ff[i] <= dprt_pkg::MAP_RST;
			end else if (wr_fire && idx == dprt_pkg::IDX_MAP_08_09 + 10'(i)) begin
				map_ff[i] <= apb_req.pwdata[7:0] & dprt_pkg::MAP_MASK;
			end
		end
	end

	// remap enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remap_en_ff <= dprt_pkg::EN_RST;
		end else if (wr_fire && idx == dprt_pkg::IDX_REMAP_EN) begin
			remap_en_ff <= apb_req.pwdata[dprt_pkg::EN_BIT];
		end
	end

	dprt_lookup #(
		.NUM_MAP (dprt_pkg::NUM_MAP)
	) u_lookup (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.remap_en   (remap_en_ff),
		.table_regs (map_ff),
		.req        (lkp_req),
		.res        (lkp_res)
	);

	// last lookup: dscp 13:8, miss 4, remapped 3, prio 2:0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_ff <= '0;
		end else if (ce && lkp_res.valid) begin
			last_ff <= {lkp_res.dscp, 3'h0, lkp_res.miss, lkp_res.remapped, lkp_res.prio};
		end
	end

	// lookup counters, saturating; a write clears, a same-cycle count restarts the counter at 1
	assign cnt_evt[0] = lkp_res.valid & lkp_res.remapped & ~lkp_res.miss;
	assign cnt_evt[1] = lkp_res.valid & ~lkp_res.remapped;
	assign cnt_evt[2] = lkp_res.valid & lkp_res.miss;
	assign cnt_clr[0] = wr_fire & (idx == dprt_pkg::IDX_CNT_REMAP);
	assign cnt_clr[1] = wr_fire & (idx == dprt_pkg::IDX_CNT_DIRECT);
	assign cnt_clr[2] = wr_fire & (idx == dprt_pkg::IDX_CNT_MISS);

	for (genvar c = 0; c < dprt_pkg::NUM_CNT; c++) begin : g_cnt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_ff[c] <= dprt_pkg::CNT_RST;
			end else if (ce) begin
				if (cnt_clr[c]) begin
					cnt_ff[c] <= cnt_evt[c] ? 16'h0001 : dprt_pkg::CNT_RST;
				end else if (cnt_evt[c] && cnt_ff[c] != dprt_pkg::CNT_MAX) begin
					cnt_ff[c] <= cnt_ff[c] + 16'h0001;
				end
			end
		end
	end
endmodule

/* File: hw/dprt_pkg.sv */
package dprt_pkg;
	// bus and field widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int DSCP_W = 6;
	localparam int PRIO_W = 3;
	localparam int CNT_W  = 16;
	localparam int NUM_MAP = 11;
	localparam int NUM_CNT = 3;

	// register indices, byte address is four times the index
	localparam logic [9:0] IDX_REMAP_EN   = 10'h33E;
	localparam logic [9:0] IDX_MAP_08_09  = 10'h344;
	localparam logic [9:0] IDX_MAP_0A_0B  = 10'h345;
	localparam logic [9:0] IDX_MAP_0C_0D  = 10'h346;
	localparam logic [9:0] IDX_MAP_0E_0F  = 10'h347;
	localparam logic [9:0] IDX_MAP_10_11  = 10'h348;
	localparam logic [9:0] IDX_MAP_12_13  = 10'h349;
	localparam logic [9:0] IDX_MAP_14_15  = 10'h34A;
	localparam logic [9:0] IDX_MAP_16_17  = 10'h34B;
	localparam logic [9:0] IDX_MAP_18_19  = 10'h34C;
	localparam logic [9:0] IDX_MAP_1A_1B  = 10'h34D;
	localparam logic [9:0] IDX_MAP_1C_1D  = 10'h34E;
	localparam logic [9:0] IDX_LAST_LKP   = 10'h380;
	localparam logic [9:0] IDX_CNT_REMAP  = 10'h381;
	localparam logic [9:0] IDX_CNT_DIRECT = 10'h382;
	localparam logic [9:0] IDX_CNT_MISS   = 10'h383;

	// field layout and reset values
	localparam logic [7:0]  MAP_RST   = 8'h00;
	localparam logic [7:0]  MAP_MASK  = 8'h77;
	localparam int          HI_LSB    = 4;
	localparam int          LO_LSB    = 0;
	localparam int          EN_BIT    = 0;
	localparam logic        EN_RST    = 1'h0;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [DSCP_W-1:0] DSCP_FIRST = 6'h08;
	localparam logic [DSCP_W-1:0] DSCP_LAST  = 6'h1D;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [3:0]        pstrb;
	} dprt_apb_req_t;

	typedef struct packed {
		logic              valid;
		logic [DSCP_W-1:0] dscp;
	} dprt_lkp_req_t;

	typedef struct packed {
		logic              valid;
		logic [DSCP_W-1:0] dscp;
		logic [PRIO_W-1:0] prio;
		logic              remapped;
		logic              miss;
	} dprt_lkp_res_t;
endpackage

/* File: hw/dprt_apb_slave.sv */
`timescale 1ns/100ps
module dprt_apb_slave (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	// bus side
	input  wire dprt_pkg::dprt_apb_req_t     req,
	output      logic [dprt_pkg::DATA_W-1:0] prdata,
	output      logic                        pready,
	output      logic                        pslverr,
	// register file side
	input  wire logic [dprt_pkg::DATA_W-1:0] rd_data,
	input  wire logic                        mapped,
	output      logic                        wr_fire
);
	logic access;

	assign access  = req.psel & req.penable;
	// write lands on the completing edge only
	assign wr_fire = ce & access & pready & req.pwrite & mapped & req.pstrb[0];

	// one wait state, answer registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			if (access && !pready) begin
				pready  <= 1'b1;
				pslverr <= ~mapped;
				prdata  <= (req.pwrite || !mapped) ? '0 : rd_data;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

/* File: hw/dprt_lookup.sv */
`timescale 1ns/100ps
module dprt_lookup #(
	parameter int NUM_MAP = dprt_pkg::NUM_MAP
) (
	// clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	// table and mode
	input  wire logic                       remap_en,
	input  wire logic [NUM_MAP-1:0][7:0]    table_regs,
	// classifier side
	input  wire dprt_pkg::dprt_lkp_req_t    req,
	output      dprt_pkg::dprt_lkp_res_t    res
);
	logic [4:0]                  pair;
	logic [4:0]                  slot;
	logic                        in_slice;
	logic [7:0]                  entry;
	logic [dprt_pkg::PRIO_W-1:0] pick;

	always_comb begin
		pair     = req.dscp[dprt_pkg::DSCP_W-1:1];
		slot     = pair - dprt_pkg::DSCP_FIRST[dprt_pkg::DSCP_W-1:1];
		in_slice = (req.dscp >= dprt_pkg::DSCP_FIRST) && (req.dscp <= dprt_pkg::DSCP_LAST);
		entry    = 8'h00;
		if (in_slice && slot < 5'(NUM_MAP)) begin
			entry = table_regs[slot[3:0]];
		end
		pick = req.dscp[0] ? entry[dprt_pkg::HI_LSB +: dprt_pkg::PRIO_W]
		                   : entry[dprt_pkg::LO_LSB +: dprt_pkg::PRIO_W];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res <= '0;
		end else if (ce) begin
			res.valid <= req.valid;
			if (req.valid) begin
				res.dscp <= req.dscp;
				if (remap_en) begin
					res.prio     <= pick;
					res.remapped <= 1'b1;
					res.miss     <= ~in_slice;
				end else begin
					res.prio     <= req.dscp[5:3];
					res.remapped <= 1'b0;
					res.miss     <= 1'b0;
				end
			end
		end
	end
endmodule

/* File: bench/dprt_remap_table_assertions.sv */
`timescale 1ns/100ps
module dprt_remap_table_assertions (
	// clock and reset
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        ce,
	// bus and lookup
	input wire dprt_pkg::dprt_apb_req_t     apb_req,
	input wire logic [dprt_pkg::DATA_W-1:0] prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire dprt_pkg::dprt_lkp_req_t     lkp_req,
	input wire dprt_pkg::dprt_lkp_res_t     lkp_res
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic tbl = apb_req.paddr >= 12'hD10 && apb_req.paddr <= 12'hD38 && apb_req.paddr[1:0] == 2'h0;
	lkp_lat_a: assert property (lkp_req.valid && ce |=> lkp_res.valid) else $error("lookup answer late");
	lkp_echo_a: assert property (lkp_req.valid && ce |=> lkp_res.dscp == $past(lkp_req.dscp))
		else $error("lookup code not echoed");
	direct_prio_a: assert property (lkp_res.valid && !lkp_res.remapped && !lkp_res.miss
		|-> lkp_res.prio == lkp_res.dscp[5:3]) else $error("direct priority wrong");
	miss_zero_a: assert property (lkp_res.valid && lkp_res.miss |-> lkp_res.prio == 3'h0 && lkp_res.remapped)
		else $error("miss priority wrong");
	hit_range_a: assert property (lkp_res.valid && lkp_res.remapped
		|-> (lkp_res.dscp >= 6'h08 && lkp_res.dscp <= 6'h1D) == !lkp_res.miss) else $error("hit outside slice");
	ready_wait_a: assert property (apb_req.psel && apb_req.penable && !pready && ce |=> pready)
		else $error("bus answer late");
	ready_pulse_a: assert property (pready && ce |=> !pready) else $error("ready longer than one cycle");
	resv_zero_a: assert property (pready && !apb_req.pwrite && tbl
		|-> prdata[31:7] == 25'h0 && !prdata[3] && !pslverr) else $error("reserved bits set");
	misalign_err_a: assert property (pready && apb_req.paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
		else $error("misaligned access accepted");
	cover property (pready && apb_req.pwrite && tbl);
	cover property (lkp_res.valid && lkp_res.remapped);
	cover property (lkp_res.valid && lkp_res.miss);
	cover property (pready && pslverr);
endmodule

/* File: bench/dprt_remap_table_test.sv */
`timescale 1ns/100ps
module dprt_remap_table_test;
	logic                    pclk = 1'h0;
	logic                    presetn = 1'h0;
	logic                    ce = 1'h1;
	dprt_pkg::dprt_apb_req_t apb_req = '0;
	dprt_pkg::dprt_lkp_req_t lkp_req = '0;
	dprt_pkg::dprt_lkp_res_t lkp_res;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	int                      mismatches = 0;
	int                      check_count = 0;
	logic [7:0]              m [11];
	logic                    en = 1'h0;
	logic [31:0]             rd;
	logic [31:0]             wd;
	logic                    err;
	logic [13:0]             last_exp = 14'h0;
	int                      n_hit = 0;
	int                      n_dir = 0;
	int                      n_miss = 0;
	always #10 pclk = ~pclk;
	dprt_remap_table i_dprt_remap_table (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lkp_req(lkp_req), .lkp_res(lkp_res));
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk) apb_req <= '{1'b1, 1'b0, wr, a, d, 4'hF};
		@(posedge pclk) apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		apb_req <= '0;
		if (n >= 20) begin
			mismatches++;
			stop_test();
		end
	endtask
	function automatic logic [11:0] exp_lkp(input logic [5:0] d);
		logic hit;
		logic [2:0] p;
		hit = en && d >= 6'h08 && d <= 6'h1D;
		p = !en ? d[5:3] : !hit ? 3'h0 : d[0] ? m[d/2-4][6:4] : m[d/2-4][2:0];
		return {1'b1, en, en && !hit, d, p};
	endfunction
	task lkp(input logic [5:0] d);
		logic [11:0] e;
		e = exp_lkp(d);
		@(posedge pclk) lkp_req <= '{1'b1, d};
		@(posedge pclk) lkp_req <= '{1'b0, d};
		#1;
		chk("lookup", e, {lkp_res.valid, lkp_res.remapped, lkp_res.miss, lkp_res.dscp, lkp_res.prio});
		last_exp = {e[8:3], 3'h0, e[9], e[10], e[2:0]};
		if (!e[10]) n_dir++;
		else if (e[9]) n_miss++;
		else n_hit++;
	endtask
	initial begin
		void'($urandom(69));
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, 12'hD10 + 12'(i * 4), 32'h0);
			chk("reset value", 32'h0, rd);
		end
		$display("reset test done");
		for (int i = 0; i < 11; i++) begin
			wd = $urandom;
			m[i] = wd[7:0] & 8'h77;
			apb(1'b1, 12'hD10 + 12'(i * 4), wd);
		end
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, 12'hD10 + 12'(i * 4), 32'h0);
			chk("table readback", {24'h0, m[i]}, rd);
			chk("table error", 32'h0, {31'h0, err});
		end
		$display("readback test done");
		apb(1'b1, 12'hD12, 32'hFF);
		chk("misaligned error", 32'h1, {31'h0, err});
		apb(1'b0, 12'hD10, 32'h0);
		chk("misaligned write ignored", {24'h0, m[0]}, rd);
		apb(1'b0, 12'hD3C, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		$display("refusal test done");
		for (int ph = 0; ph < 3; ph++) begin
			en = ph == 1;
			apb(1'b1, 12'hCF8, {31'h0, en});
			apb(1'b0, 12'hCF8, 32'h0);
			chk("enable readback", {31'h0, en}, rd);
			for (int d = 0; d < 64; d++) lkp(6'(d));
			$display("lookup phase %0d done", ph);
		end
		@(posedge pclk) ce <= 1'b0;
		lkp_req <= '{1'b1, 6'h09};
		@(posedge pclk) lkp_req <= '0;
		@(posedge pclk) ce <= 1'b1;
		#1;
		chk("frozen lookup", {1'b0, last_exp[13:8]}, {lkp_res.valid, lkp_res.dscp});
		$display("clock enable test done");
		apb(1'b0, 12'hE00, 32'h0);
		chk("last lookup", {18'h0, last_exp}, rd);
		apb(1'b0, 12'hE04, 32'h0);
		chk("hit count", 32'(n_hit), rd);
		apb(1'b0, 12'hE08, 32'h0);
		chk("direct count", 32'(n_dir), rd);
		apb(1'b0, 12'hE0C, 32'h0);
		chk("miss count", 32'(n_miss), rd);
		apb(1'b1, 12'hE0C, 32'h0);
		apb(1'b0, 12'hE0C, 32'h0);
		chk("miss count cleared", 32'h0, rd);
		$display("status test done");
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'hD10, 32'h0);
		chk("table after reset", 32'h0, rd);
		apb(1'b0, 12'hCF8, 32'h0);
		chk("enable after reset", 32'h0, rd);
		chk("lookup after reset", 32'h0, {20'h0, lkp_res});
		$display("mid-run reset test done");
		stop_test();
	end
endmodule
bind dprt_remap_table dprt_remap_table_assertions i_dprt_remap_table_assertions (.pclk(pclk), .presetn(presetn),
	.ce(ce), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lkp_req(lkp_req),
	.lkp_res(lkp_res));
